// *** watchdog_power_save_control.sv ***
// Watchdog and Sleep/Idle sequencing with wake-up status flags.
// Assumes the core issues one-cycle instruction strobes and fuses are stable.
//
// Contract
// - Watchdog fuse bit one always enables watchdog.
// - Erased fuses read one, watchdog enabled.
// - Overflow resets device, or wakes from Sleep or Idle.
// - Fuse zero: soft enable bit five rules.
// - Power-save instruction enters Sleep or Idle.
// - Sleep gates CPU, peripherals and oscillator.
// - Sleep keeps RC on for watchdog.
// - Interrupt, reset or time-out ends low power.
// - Wake restarts previous clock, fuses after POR.
// - Crystal wake waits start-up timer and lock.
// - RC or external clock waits power-on delay.
// - Running low-power crystal waits power-on delay only.
// - Interrupt wake from Sleep sets Sleep flag.
// - Dead clock: trap with monitor, else wait.
// - Non-POR reset sets Sleep flag; POR clears.
// - Watchdog wake from Sleep sets both flags.
// - Idle stops only the CPU clock.
// - Idle wake resumes at once, no delay.
// - Idle flag on interrupt wake or non-POR reset.
// - Watchdog wake from Idle sets both flags.
// - Seven 24-bit config words, low 16 used.
// - Watchdog counts on its own RC clock.
`timescale 1ns/10ps
module watchdog_power_save_control
  import wdt_pwrsave_pkg::*;
#(
  parameter int          wdt_width         = 16,
  parameter int          powerup_cycles    = 8192,
  parameter int          startup_cycles    = 8192,
  parameter int          settle_cycles     = 4096,
  parameter logic [15:0] osc_fuse_init     = erased_fuse_value,
  parameter logic [15:0] wdt_fuse_init     = erased_fuse_value,
  parameter logic [15:0] borpor_fuse_init  = erased_fuse_value,
  parameter logic [15:0] boot_fuse_init    = erased_fuse_value,
  parameter logic [15:0] secure_fuse_init  = erased_fuse_value,
  parameter logic [15:0] general_fuse_init = erased_fuse_value,
  parameter logic [15:0] debug_fuse_init   = erased_fuse_value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        power_on_reset,
  input  wire logic        brownout_reset,
  input  wire logic        master_clear_reset,
  input  wire logic        software_reset,
  input  wire logic        power_save_instr,
  input  wire logic        power_save_idle,
  input  wire logic        clear_watchdog_instr,
  input  wire logic        wake_interrupt,
  input  wire logic        low_power_rc_osc_tick,
  input  wire logic        clock_switch_enable,
  input  wire logic [2:0]  current_osc_select,
  input  wire logic [2:0]  fuse_osc_select,
  input  wire logic        low_power_crystal_on,
  input  wire logic        pll_lock,
  input  wire logic        osc_running,
  input  wire logic        clock_fail_monitor_en,
  input  wire logic        brownout_enable,
  input  wire logic        status_write,
  input  wire logic [15:0] status_wdata,
  input  wire logic        table_read,
  input  wire logic [23:0] table_addr,
  output logic [15:0]      reset_control_status,
  output logic [23:0]      table_rdata,
  output logic             table_hit,
  output logic             cpu_clock_en,
  output logic             periph_clock_en,
  output logic             osc_enable,
  output logic             low_power_rc_osc_enable,
  output logic             clock_monitor_active,
  output logic             brownout_active,
  output logic [2:0]       wake_osc_select,
  output logic             watchdog_reset,
  output logic             clock_fail_trap,
  output logic             fast_rc_force,
  output logic             interrupt_vector_take
);

  localparam int cnt_w = 16;

  power_state_type  state;
  power_state_type  next_state;
  logic [cnt_w-1:0] delay_count;
  logic [2:0]       osc_choice;
  logic             fuse_chosen;
  logic             wake_by_int;
  logic             wdt_overflow;

  // Decode of the wake-up delay for the chosen oscillator.
  function automatic logic [cnt_w-1:0] wake_delay(input logic [2:0] osc, input logic lp_kept,
                                                  input logic after_por);
    logic [cnt_w-1:0] d;
    d = cnt_w'(power_on_cycles);
    if ((osc == osc_low_power_xtal) && lp_kept && !after_por) begin
      d = cnt_w'(power_on_cycles);
    end else if ((osc == osc_crystal) || (osc == osc_low_power_xtal)) begin
      d = cnt_w'(power_on_cycles + powerup_cycles + startup_cycles);
    end else if (osc == osc_crystal_pll) begin
      d = cnt_w'(power_on_cycles + powerup_cycles + startup_cycles + settle_cycles);
    end
    return d;
  endfunction : wake_delay

  // Fuse words are constant after programming; erased parts read all ones.
  wire [15:0] fuse_word [cfg_word_count] = '{osc_fuse_init, wdt_fuse_init, borpor_fuse_init,
                                              boot_fuse_init, secure_fuse_init,
                                              general_fuse_init, debug_fuse_init};
  wire [23:0] addr_offset  = table_addr - osc_cfg_addr;
  wire [2:0]  word_index   = addr_offset[3:1];
  wire        addr_in_map  = (table_addr >= osc_cfg_addr) && (table_addr <= debug_cfg_addr)
                             && !table_addr[0];
  wire        fuse_wdt_en  = wdt_fuse_init[wdt_fuse_en_bit];
  wire        wdt_enabled  = fuse_wdt_en || reset_control_status[reset_control_status_soft_en_bit];
  wire        any_reset    = power_on_reset || brownout_reset || master_clear_reset || software_reset;
  wire        in_sleep     = (state == sleep_state);
  wire        in_idle      = (state == idle_state);
  wire        low_power    = in_sleep || in_idle;
  wire        wake_event   = wake_interrupt || wdt_overflow;
  wire        delay_done   = (delay_count == '0);
  wire        clock_ready  = osc_running && ((osc_choice != osc_crystal_pll) || pll_lock);
  wire [2:0]  restart_osc  = (fuse_chosen || power_on_reset || brownout_reset || !clock_switch_enable)
                             ? fuse_osc_select : current_osc_select;
  wire        wdt_restart  = clear_watchdog_instr || any_reset;

  watchdog_counter #(
    .width    (wdt_width)
  ) u_watchdog_counter (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (wdt_enabled),
    .restart   (wdt_restart),
    .low_power_rc_osc_tick (low_power_rc_osc_tick),
    .overflow  (wdt_overflow)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      run_state: begin
        if (power_save_instr && !any_reset) begin
          next_state = power_save_idle ? idle_state : sleep_state;
        end
      end
      idle_state: begin
        if (wake_event) begin
          next_state = run_state;
        end
      end
      sleep_state: begin
        if (wake_event) begin
          next_state = wake_state;
        end
      end
      wake_state: begin
        if (delay_done) begin
          next_state = clock_ready ? run_state : hold_state;
        end
      end
      hold_state: begin
        if (clock_ready || clock_fail_monitor_en) begin
          next_state = run_state;
        end
      end
      default: begin
        next_state = run_state;
      end
    endcase
    if (any_reset) begin
      next_state = (in_sleep || (state == wake_state) || (state == hold_state) || in_idle)
                   ? wake_state : run_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= run_state;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_count <= '0;
      osc_choice  <= osc_fast_rc;
      fuse_chosen <= 1'b1;
      wake_by_int <= 1'b0;
    end else begin
      if (power_on_reset || brownout_reset) begin
        fuse_chosen <= 1'b1;
      end else if (next_state == run_state) begin
        fuse_chosen <= 1'b0;
      end
      if ((next_state == wake_state) && (state != wake_state)) begin
        osc_choice  <= restart_osc;
        delay_count <= wake_delay(restart_osc, low_power_crystal_on,
                                  fuse_chosen || power_on_reset || brownout_reset);
      end else if (!delay_done) begin
        delay_count <= delay_count - 1'b1;
      end
      if (low_power && wake_interrupt && !any_reset) begin
        wake_by_int <= 1'b1;
      end else if (next_state == run_state) begin
        wake_by_int <= 1'b0;
      end
    end
  end

  // Status register: hardware sets win over software writes in the same cycle.
  wire [15:0] soft_status = status_write
                            ? ((reset_control_status & ~reset_control_status_writable_mask) | (status_wdata & reset_control_status_writable_mask))
                            : reset_control_status;
  wire [15:0] set_bits    = ({15'h0, brownout_reset} << reset_control_status_bor_bit)
                          | ({15'h0, (any_reset && !power_on_reset && in_sleep) ||
                                     (in_sleep && wake_event)} << reset_control_status_sleep_bit)
                          | ({15'h0, (any_reset && !power_on_reset && in_idle) ||
                                     (in_idle && wake_event)} << reset_control_status_idle_bit)
                          | ({15'h0, wdt_overflow && !any_reset} << reset_control_status_watchdog_timeout_flag_bit)
                          | ({15'h0, software_reset} << reset_control_status_swr_bit)
                          | ({15'h0, master_clear_reset} << reset_control_status_extr_bit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_control_status <= reset_control_status_por_value;
    end else if (power_on_reset) begin
      reset_control_status <= reset_control_status_por_value;
    end else begin
      reset_control_status <= soft_status | set_bits;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      table_rdata <= 24'h0;
      table_hit   <= 1'b0;
    end else begin
      table_hit   <= table_read && addr_in_map;
      table_rdata <= (table_read && addr_in_map)
                     ? {{(24 - cfg_data_bits){1'b0}}, fuse_word[word_index]} : 24'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clock_en          <= 1'b1;
      periph_clock_en       <= 1'b1;
      osc_enable            <= 1'b1;
      low_power_rc_osc_enable           <= 1'b1;
      clock_monitor_active  <= 1'b0;
      brownout_active       <= 1'b0;
      wake_osc_select       <= osc_fast_rc;
      watchdog_reset        <= 1'b0;
      clock_fail_trap       <= 1'b0;
      fast_rc_force         <= 1'b0;
      interrupt_vector_take <= 1'b0;
    end else begin
      cpu_clock_en          <= (next_state == run_state);
      periph_clock_en       <= (next_state == run_state) || (next_state == idle_state);
      osc_enable            <= (next_state != sleep_state) ||
                               (low_power_crystal_on && (osc_choice == osc_low_power_xtal));
      low_power_rc_osc_enable           <= wdt_enabled || (clock_fail_monitor_en && (next_state != sleep_state));
      clock_monitor_active  <= clock_fail_monitor_en && (next_state != sleep_state);
      brownout_active       <= brownout_enable;
      wake_osc_select       <= (next_state == wake_state) && (state != wake_state) ? restart_osc
                                                                                  : wake_osc_select;
      watchdog_reset        <= wdt_overflow && !low_power;
      clock_fail_trap       <= (state == wake_state) && delay_done && !clock_ready
                               && clock_fail_monitor_en;
      fast_rc_force         <= fast_rc_force ||
                               ((state == wake_state) && delay_done && !clock_ready
                                && clock_fail_monitor_en);
      interrupt_vector_take <= (state != run_state) && (next_state == run_state) &&
                               (wake_by_int || (in_idle && wake_interrupt));
    end
  end

endmodule : watchdog_power_save_control

// *** wdt_pwrsave_pkg.sv ***
// Constants for the watchdog and power-save controller.
// Assumes a 200 MHz core clock and configuration words held in fuses.
package wdt_pwrsave_pkg;

  localparam logic [23:0] osc_cfg_addr       = 24'hf80000;
  localparam logic [23:0] wdt_cfg_addr       = 24'hf80002;
  localparam logic [23:0] borpor_cfg_addr    = 24'hf80004;
  localparam logic [23:0] boot_cfg_addr      = 24'hf80006;
  localparam logic [23:0] secure_cfg_addr    = 24'hf80008;
  localparam logic [23:0] general_cfg_addr   = 24'hf8000a;
  localparam logic [23:0] debug_cfg_addr     = 24'hf8000c;
  localparam int          cfg_word_count     = 7;
  localparam int          cfg_data_bits      = 16;

  localparam int          wdt_fuse_en_bit    = 15;
  localparam logic [15:0] erased_fuse_value  = 16'hffff;

  localparam int          reset_control_status_por_bit       = 0;
  localparam int          reset_control_status_bor_bit       = 1;
  localparam int          reset_control_status_idle_bit      = 2;
  localparam int          reset_control_status_sleep_bit     = 3;
  localparam int          reset_control_status_watchdog_timeout_flag_bit      = 4;
  localparam int          reset_control_status_soft_en_bit   = 5;
  localparam int          reset_control_status_swr_bit       = 6;
  localparam int          reset_control_status_extr_bit      = 7;
  localparam logic [15:0] reset_control_status_writable_mask = 16'hc0ff;
  localparam logic [15:0] reset_control_status_por_value     = 16'h0003;

  localparam int          clk_mhz            = 200;
  localparam int          power_on_delay_ns  = 10000;
  localparam int          power_on_cycles    = (power_on_delay_ns * clk_mhz + 999) / 1000;

  localparam logic [2:0]  osc_external_clock = 3'h0;
  localparam logic [2:0]  osc_fast_rc        = 3'h1;
  localparam logic [2:0]  osc_low_power_rc   = 3'h2;
  localparam logic [2:0]  osc_external_rc    = 3'h3;
  localparam logic [2:0]  osc_low_power_xtal = 3'h4;
  localparam logic [2:0]  osc_crystal        = 3'h5;
  localparam logic [2:0]  osc_crystal_pll    = 3'h6;

  typedef enum logic [2:0] {
    run_state   = 3'b000,
    idle_state  = 3'b001,
    sleep_state = 3'b010,
    wake_state  = 3'b011,
    hold_state  = 3'b100
  } power_state_type;

endpackage : wdt_pwrsave_pkg

// *** watchdog_counter.sv ***
// Watchdog counter clocked from the low-power RC oscillator tick.
// Assumes low_power_rc_osc_tick is a one-cycle pulse synchronous to clk.
`timescale 1ns/10ps
module watchdog_counter #(
  parameter int width = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic restart,
  input  wire logic low_power_rc_osc_tick,
  output logic      overflow
);

  logic [width-1:0] count;
  wire              at_top = &count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count    <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= enable && !restart && low_power_rc_osc_tick && at_top;
      if (restart || !enable) begin
        count <= '0;
      end else if (low_power_rc_osc_tick) begin
        count <= count + 1'b1;
      end
    end
  end

endmodule : watchdog_counter

// *** wdt_pwrsave_asserts.sv ***
// Port checker for the watchdog and power-save controller.
// Assumes the bind at the foot reaches every controller instance.
`timescale 1ns/10ps
module wdt_pwrsave_checker
  import wdt_pwrsave_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        power_on_reset,
  input wire logic        master_clear_reset,
  input wire logic        power_save_instr,
  input wire logic        power_save_idle,
  input wire logic        wake_interrupt,
  input wire logic        table_read,
  input wire logic [23:0] table_addr,
  input wire logic [15:0] reset_control_status,
  input wire logic [23:0] table_rdata,
  input wire logic        table_hit,
  input wire logic        cpu_clock_en,
  input wire logic        periph_clock_en,
  input wire logic        osc_enable,
  input wire logic        clock_monitor_active,
  input wire logic        watchdog_reset,
  input wire logic        clock_fail_trap,
  input wire logic        fast_rc_force,
  input wire logic        interrupt_vector_take
);
  int unsigned off_cnt;
  wire         run_ok = cpu_clock_en && !power_on_reset && !master_clear_reset && !wake_interrupt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts the cycles that the peripheral clock has been off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      off_cnt <= 0;
    else
      off_cnt <= periph_clock_en ? 0 : off_cnt + 1;
  end
  a_cfg_read: assert property (
    table_read && table_addr == wdt_cfg_addr |=> table_hit && table_rdata[23:16] == 8'h00)
    else $error("config word read bad");
  a_cfg_miss: assert property (
    table_read && table_addr[0] |=> !table_hit && table_rdata == 24'h000000)
    else $error("odd config address answered");
  a_idle_entry: assert property (
    power_save_instr && power_save_idle && run_ok |=> !cpu_clock_en && periph_clock_en && osc_enable)
    else $error("idle entry bad");
  a_sleep_entry: assert property (
    power_save_instr && !power_save_idle && run_ok |=> !cpu_clock_en && !periph_clock_en && !osc_enable)
    else $error("sleep entry bad");
  a_sleep_monitor: assert property (
    !periph_clock_en && !osc_enable |-> !clock_monitor_active)
    else $error("monitor active in sleep");
  a_idle_wake: assert property (
    !cpu_clock_en && periph_clock_en && wake_interrupt
    |=> cpu_clock_en && interrupt_vector_take && reset_control_status[2])
    else $error("idle wake bad");
  a_por_value: assert property (
    power_on_reset |=> reset_control_status == reset_control_status_por_value)
    else $error("power-on status bad");
  a_wdt_run: assert property (
    watchdog_reset |-> $past(cpu_clock_en, 2))
    else $error("watchdog reset from low power");
  a_wake_delay: assert property (
    $rose(periph_clock_en) |-> off_cnt >= power_on_cycles)
    else $error("sleep wake too early");
  a_trap_force: assert property (
    clock_fail_trap |=> fast_rc_force)
    else $error("trap without fast rc");
endmodule : wdt_pwrsave_checker

bind watchdog_power_save_control wdt_pwrsave_checker chk (.*);

// *** core_model.sv ***
// Core-side model: low-power RC ticks, periodic watchdog clears and one clear after each wake.
// Assumes the bench drives everything else at the falling edge.
`timescale 1ns/10ps
module core_model #(
  parameter int tick_period = 256,
  parameter int kick_ticks  = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic low_power_rc_osc_enable,
  input  wire logic cpu_clock_en,
  input  wire logic kick_en,
  output wire logic low_power_rc_osc_tick,
  output wire logic clear_watchdog_instr
);
  int   cyc    = 0;
  int   ticks  = 0;
  logic tick_q = 1'b0;
  logic kick_q = 1'b0;
  logic cpu_q  = 1'b1;
  assign low_power_rc_osc_tick            = tick_q;
  assign clear_watchdog_instr = kick_q;
  // The RC tick keeps its own count whatever the core clock does.
  always @(negedge clk) begin
    cyc = (cyc + 1) % tick_period;
    if (cyc == 0)
      ticks = (ticks + 1) % kick_ticks;
    tick_q <= low_power_rc_osc_enable && cyc == 0;
    kick_q <= kick_en && cpu_clock_en && rst_n && ((cyc == 0 && ticks == 0) || !cpu_q);
    cpu_q  <= cpu_clock_en;
  end
endmodule : core_model

// *** watchdog_power_save_control_tb_top.sv ***
// Self-checking bench for the watchdog and power-save controller.
// Assumes erased fuses and shortened watchdog and timer counts.
`timescale 1ns/10ps
module watchdog_power_save_control_tb_top
  import wdt_pwrsave_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, power_on_reset = 1'b0, master_clear_reset = 1'b0, kick_en = 1'b1;
  logic power_save_instr = 1'b0, power_save_idle = 1'b0, wake_interrupt = 1'b0;
  logic brownout_reset = 1'b0, software_reset = 1'b0;
  logic clock_switch_enable = 1'b1, low_power_crystal_on = 1'b0, osc_running = 1'b1, clock_fail_monitor_en = 1'b0;
  logic brownout_enable = 1'b1, status_write = 1'b0, table_read = 1'b0;
  logic [2:0] current_osc_select = osc_fast_rc;
  logic [15:0] status_wdata = 16'h0000;
  logic [23:0] table_addr = 24'h000000;
  logic low_power_rc_osc_tick, clear_watchdog_instr, table_hit, cpu_clock_en, periph_clock_en, osc_enable, low_power_rc_osc_enable;
  logic clock_monitor_active, brownout_active, watchdog_reset, clock_fail_trap, fast_rc_force, interrupt_vector_take;
  logic [15:0] reset_control_status;
  logic [23:0] table_rdata;
  logic [2:0]  wake_osc_select;
  int          total_checks = 0;
  int          n_fail = 0;
  int          wd_count = 0;
  watchdog_power_save_control #(.wdt_width(4), .powerup_cycles(4), .startup_cycles(4), .settle_cycles(4)) uut (
    .pll_lock(1'b0), .fuse_osc_select(osc_fast_rc), .*);
  core_model partner (.*);
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (watchdog_reset)
      wd_count <= wd_count + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_hi(ref logic sig, input int limit, output int n);
    n = 0;
    while (sig !== 1'b1 && n < limit) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_hi
  task automatic enter(input logic idle);
    power_save_idle = idle;
    power_save_instr = 1'b1;
    @(negedge clk);
    power_save_instr = 1'b0;
  endtask : enter
  task automatic clr();
    status_write = 1'b1;
    @(negedge clk);
    status_write = 1'b0;
  endtask : clr
  task automatic cfg_read(input logic [23:0] a, input logic [23:0] exp, input logic hit);
    table_addr = a;
    table_read = 1'b1;
    @(negedge clk);
    table_read = 1'b0;
    check({table_hit, table_rdata}, {hit, exp});
    @(negedge clk);
  endtask : cfg_read
  task automatic t_reset();
    check(reset_control_status, 16'h0003);
    check({brownout_active, low_power_rc_osc_enable, cpu_clock_en}, 3'h7);
    for (int i = 0; i < cfg_word_count; i++)
      cfg_read(osc_cfg_addr + 24'(2 * i), {8'h00, erased_fuse_value}, 1'b1);
    cfg_read(24'hf80001, 24'h000000, 1'b0);
    cfg_read(24'hf8000e, 24'h000000, 1'b0);
  endtask : t_reset
  task automatic t_idle();
    clr();
    enter(1'b1);
    check({cpu_clock_en, periph_clock_en, osc_enable}, 3'h3);
    repeat (5) @(negedge clk);
    wake_interrupt = 1'b1;
    @(negedge clk);
    wake_interrupt = 1'b0;
    check({cpu_clock_en, interrupt_vector_take, reset_control_status[2]}, 3'h7);
  endtask : t_idle
  task automatic t_sleep(input logic [2:0] osc, input logic lp, input int lo, input int hi);
    int n;
    low_power_crystal_on = lp;
    current_osc_select = osc;
    clr();
    enter(1'b0);
    check({cpu_clock_en, periph_clock_en, osc_enable & !lp, clock_monitor_active, low_power_rc_osc_enable}, 5'h01);
    wake_interrupt = 1'b1;
    wait_hi(cpu_clock_en, 4000, n);
    wake_interrupt = 1'b0;
    check(n >= lo && n <= hi, 1'b1);
    check({interrupt_vector_take, reset_control_status[3], wake_osc_select}, {2'h3, osc});
  endtask : t_sleep
  task automatic t_wdt_run();
    int n;
    repeat (6000) @(negedge clk);
    check(wd_count, 32'h0);
    kick_en = 1'b0;
    wait_hi(watchdog_reset, 8000, n);
    kick_en = 1'b1;
    repeat (2) @(negedge clk);
    check({n < 8000, reset_control_status[4]}, 2'h3);
  endtask : t_wdt_run
  task automatic t_wdt(input logic idle, input int b);
    int n;
    int w;
    current_osc_select = osc_fast_rc;
    clr();
    w = wd_count;
    enter(idle);
    wait_hi(cpu_clock_en, 8000, n);
    check({wd_count != w, reset_control_status[4], reset_control_status[b]}, 3'h3);
  endtask : t_wdt
  task automatic t_master_clear_reset();
    int n;
    clr();
    enter(1'b1);
    master_clear_reset = 1'b1;
    @(negedge clk);
    master_clear_reset = 1'b0;
    wait_hi(cpu_clock_en, 4000, n);
    check({reset_control_status[7], reset_control_status[2], reset_control_status[3]}, 3'h6);
  endtask : t_master_clear_reset
  task automatic t_resets();
    int n;
    clr();
    software_reset = 1'b1;
    @(negedge clk);
    software_reset = 1'b0;
    check({reset_control_status[6], reset_control_status[3:2], cpu_clock_en}, 4'h9);
    current_osc_select = osc_crystal;
    clr();
    enter(1'b0);
    brownout_reset = 1'b1;
    @(negedge clk);
    brownout_reset = 1'b0;
    wait_hi(cpu_clock_en, 4000, n);
    check({reset_control_status[1], reset_control_status[3], wake_osc_select}, 5'h19);
    check(n >= power_on_cycles - 2 && n <= power_on_cycles + 4, 1'b1);
  endtask : t_resets
  task automatic t_trap();
    int n;
    current_osc_select = osc_crystal;
    osc_running = 1'b0;
    clock_fail_monitor_en = 1'b1;
    enter(1'b0);
    wake_interrupt = 1'b1;
    wait_hi(clock_fail_trap, 4000, n);
    wake_interrupt = 1'b0;
    @(negedge clk);
    check({n < 4000, fast_rc_force}, 2'h3);
    power_on_reset = 1'b1;
    @(negedge clk);
    power_on_reset = 1'b0;
    check(reset_control_status, reset_control_status_por_value);
  endtask : t_trap
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_idle();
    t_sleep(osc_fast_rc, 1'b0, power_on_cycles - 2, power_on_cycles + 4);
    t_sleep(osc_low_power_xtal, 1'b1, power_on_cycles - 2, power_on_cycles + 4);
    t_sleep(osc_crystal, 1'b0, power_on_cycles + 6, power_on_cycles + 14);
    t_wdt_run();
    t_wdt(1'b0, reset_control_status_sleep_bit);
    t_wdt(1'b1, reset_control_status_idle_bit);
    t_master_clear_reset();
    t_resets();
    t_trap();
    test_done();
  end
endmodule : watchdog_power_save_control_tb_top
